// ### hdl/ddp_pump_ctrl.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`include "ddp_params.svh"
`default_nettype none
// What this block does
// R1: 12-bit RW control, system reset clears
// R2: external power absent uses battery field
// R3: external power present uses mains field
// R4: low rail uses bits 11 to 8
// R5: zero field keeps drive inactive
// R6: n of 16 slots active
// R7: half duty gives 97.7 kHz (96 kHz target, slots rounded down to 32 cycles)
// R8: latch pin level during power-on reset
// R9: latched low active high, else active low
// R10: 4-bit wrapping slot counter compare
module ddp_pump_ctrl import ddp_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        por,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        external_power_present_n,
  input  wire logic        high_rail_pin_in,
  input  wire logic        low_rail_pin_in,
  output logic             high_rail_drive,
  output logic             high_rail_drive_oe,
  output logic             low_rail_drive,
  output logic             low_rail_drive_oe
);
  // Slot rounds down to whole cycles: 97.7 kHz at half duty, not 96
  localparam int SLOT_CYC = `DDP_SLOT_CYCLES;

  // ----------------------------------------------------------------------
  // Field access
  // ----------------------------------------------------------------------
  // Picks one on-time field out of the control word
  function automatic ddp_ratio_type ratio_field(input logic [11:0] word,
                                                input int          lsb);
    ratio_field = word[lsb +: 4];
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync1_next;
  logic [2:0] sync2_next;

  always_comb begin
    sync1_next = {external_power_present_n, high_rail_pin_in,
                  low_rail_pin_in};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge sys_clk) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
  end

  // ----------------------------------------------------------------------
  // Power-on sense capture
  // ----------------------------------------------------------------------
  // Pins are released (oe low) during por so the strap level can be read;
  // sense holds the last sampled level once por falls
  logic       por_s1_reg;
  logic       por_s2_reg;
  logic       por_s1_next;
  logic       por_s2_next;
  logic [1:0] sense_reg;
  logic [1:0] sense_next;
  logic       oe_reg;
  logic       oe_next;

  always_comb begin
    por_s1_next = por;
    por_s2_next = por_s1_reg;
    sense_next = sense_reg;
    oe_next = ~por_s2_reg;
    if (por_s2_reg) begin
      sense_next = sync2_reg[1:0]; // R8
    end
  end

  always_ff @(posedge sys_clk) begin
    por_s1_reg <= por_s1_next;
    por_s2_reg <= por_s2_next;
    sense_reg  <= sense_next;
    oe_reg     <= oe_next;
  end

  // ----------------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------------
  logic [11:0] ctrl_reg;
  logic [11:0] ctrl_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ready_reg;
  logic        ready_next;
  logic        err_reg;
  logic        err_next;
  logic        setup;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        wr_ctrl;

  always_comb begin
    setup      = psel && !penable && !ready_reg;
    hit_ctrl   = paddr == `DDP_PUMP_DUTY_CONTROL_ADDR;
    hit_stat   = paddr == `DDP_SENSE_STATUS_ADDR;
    wr_ctrl    = psel && penable && ready_reg && pwrite && hit_ctrl;
    ctrl_next  = ctrl_reg;
    rdata_next = 32'h0000_0000;
    ready_next = 1'b0;
    err_next   = 1'b0;
    if (setup) begin
      // Answer in the first access cycle: no wait states
      ready_next = 1'b1;
      err_next   = !(hit_ctrl || hit_stat);
      if (!pwrite && hit_ctrl) begin
        rdata_next = {20'h0_0000, ctrl_reg}; // R1
      end else if (!pwrite && hit_stat) begin
        rdata_next = {29'h0000_0000, sync2_reg[2], sense_reg};
      end
    end
    if (wr_ctrl) begin
      ctrl_next = pwdata[11:0]; // R1
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg  <= `DDP_PUMP_DUTY_CONTROL_RESET; // R1
      rdata_reg <= 32'h0000_0000;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg   <= err_next;
    end
  end

  // ----------------------------------------------------------------------
  // Slot timebase
  // ----------------------------------------------------------------------
  logic [5:0] div_reg;
  logic [5:0] div_next;
  logic [3:0] slot_reg;
  logic [3:0] slot_next;
  logic       tick;

  always_comb begin
    tick      = div_reg == 6'(SLOT_CYC - 1);
    div_next  = tick ? 6'h00 : div_reg + 6'h01; // R7
    slot_next = tick ? slot_reg + 4'h1 : slot_reg; // R10
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_reg  <= 6'h00;
      slot_reg <= 4'h0;
    end else begin
      div_reg  <= div_next;
      slot_reg <= slot_next;
    end
  end

  // ----------------------------------------------------------------------
  // Supply select
  // ----------------------------------------------------------------------
  ddp_ratio_type high_ratio;
  ddp_ratio_type low_ratio;

  always_comb begin
    // Supply level changes apply from the next slot compare
    if (sync2_reg[2]) begin
      high_ratio = ratio_field(ctrl_reg, `DDP_BATT_FIELD_LSB); // R2
    end else begin
      high_ratio = ratio_field(ctrl_reg, `DDP_MAINS_FIELD_LSB); // R3
    end
    low_ratio = ratio_field(ctrl_reg, `DDP_LOW_FIELD_LSB); // R4
  end

  // ----------------------------------------------------------------------
  // Pump channels
  // ----------------------------------------------------------------------
  ddp_pump_channel u_high (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .slot_tick  (tick),
    .slot_count (slot_reg),
    .ratio      (high_ratio),
    .sense_low  (sense_reg[1]),
    .drive      (high_rail_drive)
  );

  ddp_pump_channel u_low (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .slot_tick  (tick),
    .slot_count (slot_reg),
    .ratio      (low_ratio), // R4
    .sense_low  (sense_reg[0]),
    .drive      (low_rail_drive)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign high_rail_drive_oe = oe_reg;
  assign low_rail_drive_oe  = oe_reg;
  assign pready  = ready_reg;
  assign prdata  = rdata_reg;
  assign pslverr = err_reg;
endmodule // ddp_pump_ctrl
`default_nettype wire

// ### hdl/ddp_params.svh
`ifndef DDP_PARAMS_SVH
`define DDP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DDP_PUMP_DUTY_CONTROL_ADDR 12'h000
`define DDP_PUMP_DUTY_CONTROL_RESET 12'h000
`define DDP_SENSE_STATUS_ADDR 12'h004
`define DDP_BATT_FIELD_LSB 0
`define DDP_MAINS_FIELD_LSB 4
`define DDP_LOW_FIELD_LSB 8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DDP_CLK_HZ 50000000
`define DDP_SQUARE_HZ 96000
`define DDP_SLOTS 16
// Longest slot rounds down: 50e6 / (96e3 * 16) = 32 cycles
`define DDP_SLOT_CYCLES (`DDP_CLK_HZ / (`DDP_SQUARE_HZ * `DDP_SLOTS))

`endif

// ### hdl/ddp_pkg.sv
`default_nettype none
package ddp_pkg;
  typedef logic [3:0] ddp_ratio_type;
endpackage
`default_nettype wire

// ### hdl/ddp_pump_channel.sv
`include "ddp_params.svh"
`default_nettype none
module ddp_pump_channel import ddp_pkg::*; (
  input  wire logic    sys_clk,
  input  wire logic    rst,
  input  wire logic    slot_tick,
  input  wire logic [3:0] slot_count,
  input  var  ddp_ratio_type ratio,
  input  wire logic    sense_low,
  output logic         drive
);
  logic drive_reg;
  logic drive_next;

  // ----------------------------------------------------------------------
  // Mark-space compare
  // ----------------------------------------------------------------------
  always_comb begin
    drive_next = drive_reg;
    if (slot_tick) begin
      // Zero ratio never passes compare: pump off
      drive_next = (slot_count < ratio) ^ sense_low; // R5 R6 R10 R9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Idle at the inactive level, never the active one
      drive_reg <= sense_low; // R5 R9
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign drive = drive_reg;
endmodule // ddp_pump_channel
`default_nettype wire

// ### sim/ddp_pump_model.sv
`default_nettype none
// Strap resistor sets the pin while the device floats it
module ddp_pump_model #(parameter logic STRAP = 1'b0) (
  input  wire logic drive,
  input  wire logic oe,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin = oe ? drive : STRAP;
endmodule // ddp_pump_model
`default_nettype wire

// ### sim/ddp_pump_ctrl_sva.sv
`default_nettype none
module ddp_pump_ctrl_sva (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        por,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        high_rail_drive,
  input wire logic        high_rail_drive_oe,
  input wire logic        low_rail_drive_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ready_prompt: assert property (psel && !penable |=> pready)
    else $error("ready missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_read_upper: assert property (pready |-> prdata[31:12] == 20'h0)
    else $error("upper bits set");
  a_err_map: assert property (pready |->
    pslverr == !(paddr inside {12'h000, 12'h004})) else $error("bad err");
  a_idle_data: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("idle data");
  a_oe_por: assert property (por [*4] |->
    !high_rail_drive_oe && !low_rail_drive_oe)
    else $error("pin driven in por");
  a_oe_back: assert property (!por [*5] |->
    high_rail_drive_oe && low_rail_drive_oe) else $error("pin floats");
  // Slots are 32 cycles, so a drive edge never follows another soon
  a_drive_hold: assert property ($changed(high_rail_drive) &&
    high_rail_drive_oe && $past(high_rail_drive_oe) |=>
    $stable(high_rail_drive) [*8])
    else $error("drive glitch");
endmodule // ddp_pump_ctrl_sva
bind ddp_pump_ctrl ddp_pump_ctrl_sva ddp_pump_ctrl_sva_inst (
  .sys_clk(sys_clk), .rst(rst), .por(por), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .high_rail_drive(high_rail_drive),
  .high_rail_drive_oe(high_rail_drive_oe),
  .low_rail_drive_oe(low_rail_drive_oe));
`default_nettype wire

// ### sim/ddp_pump_ctrl_tb.sv
`include "ddp_params.svh"
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  error_cnt++; $display("wrong value at %0t: %h %h", $time, a, e); end end
module ddp_pump_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, rst = 1, por = 1, psel = 0, penable = 0;
  logic        pwrite = 0, ext_n = 1, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  wire logic   pready, pslverr, hi_pin, lo_pin, hi_drv, hi_oe, lo_drv, lo_oe;
  wire logic [31:0] prdata;
  int          error_cnt = 0, check_count = 0, cyc = 0, nh, nl;
  always #10 sys_clk = ~sys_clk;
  ddp_pump_ctrl ddp_pump_ctrl_inst (.sys_clk, .rst, .por, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .external_power_present_n(ext_n), .high_rail_pin_in(hi_pin),
    .low_rail_pin_in(lo_pin), .high_rail_drive(hi_drv),
    .high_rail_drive_oe(hi_oe), .low_rail_drive(lo_drv),
    .low_rail_drive_oe(lo_oe));
  ddp_pump_model #(.STRAP(1'b0)) ddp_pump_model_inst (.drive(hi_drv),
    .oe(hi_oe), .pin(hi_pin));
  ddp_pump_model #(.STRAP(1'b1)) ddp_pump_model_inst_lo (.drive(lo_drv),
    .oe(lo_oe), .pin(lo_pin));
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Any 512-cycle window holds exactly one full pump period
  task meas;
    nh = 0;
    nl = 0;
    repeat (64) @(posedge sys_clk);
    repeat (512) begin
      @(negedge sys_clk);
      nh += (hi_drv === 1'b1);
      nl += (lo_drv === 1'b0);
    end
    @(posedge sys_clk);
  endtask
  task reg_scn;
    apb(12'h000, 0, 0);
    `CHK(rd, 32'h0)
    `CHK(hi_drv, 1'b0)
    `CHK(lo_drv, 1'b1)
    apb(12'h000, 1, 32'hffff_fabc);
    apb(12'h000, 0, 0);
    `CHK(rd, 32'h0000_0abc)
    apb(12'h008, 1, 32'h1);
    `CHK(er, 1'b1)
    apb(12'h004, 0, 0);
    `CHK(rd, 32'h0000_0005)
  endtask
  task duty_scn;
    for (int k = 0; k < 16; k += 5) begin
      ext_n <= 1;
      apb(12'h000, 1, {20'h0, k[3:0], 4'h0, k[3:0]});
      meas;
      `CHK(nh, k * `DDP_SLOT_CYCLES)
      `CHK(nl, k * `DDP_SLOT_CYCLES)
      ext_n <= 0;
      apb(12'h000, 1, {20'h0, 4'h0, k[3:0], 4'h0});
      meas;
      `CHK(nh, k * `DDP_SLOT_CYCLES)
      `CHK(nl, 0)
    end
  endtask
  task por_scn;
    por <= 1;
    repeat (6) @(posedge sys_clk);
    `CHK(hi_oe, 1'b0)
    por <= 0;
    repeat (6) @(posedge sys_clk);
    `CHK(lo_oe, 1'b1)
    apb(12'h004, 0, 0);
    `CHK(rd[1:0], 2'b01)
  endtask
  task complete_run;
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    por <= 0;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    reg_scn;
    duty_scn;
    por_scn;
    complete_run;
  end
endmodule // ddp_pump_ctrl_tb
`default_nettype wire
